// file: core/bcap_regs.sv
// Blit color and alpha parameter bank with APB slave and parameter datapath helpers
//
// What this block does
// - Flag a pixel equal to the depth-masked key color as transparent.
// - Depth code 10b uses all 32 bits of key and fill colors.
// - Depth code 01b uses only the low 16 color bits.
// - Eight bits per pixel uses only the low 8 color bits.
// - Operation code 011b drives the fill color to every destination pixel.
// - Start position applies only for 1-bit format with expansion enabled.
// - Effective start is source address bit 0 plus programmed start.
// - Width field 00/01/10/11 selects 1/2/4/8 bit indexes.
// - Fields are consumed most significant first as lookup indexes.
// - One-bit format byte-swaps the 16-bit source word first.
// - Wider formats reverse bit order inside each field.
// - Blending enabled takes source format from blend field, ignoring depth.
// - Blend formats 1555, 4444, 8888; destination and result RGB 5:6:5.
// - Constant alpha is supplied where a selection asks for it.
// - Alpha select: map, one minus map, constant, one minus constant.
// - Each channel is source alpha times source plus destination term.
`timescale 1ns/1ns
module bcap_regs
  import bcap_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [BCAP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Key compare and fill
  input  wire logic                   pixel_valid,
  input  wire logic [31:0]            pixel_data,
  output logic                        key_match,
  output logic                        key_match_valid,
  output logic                        fill_active,
  output logic      [31:0]            fill_pixel,
  output logic      [1:0]             source_format,
  output logic                        source_is_blend,
  // Color expansion
  input  wire logic                   src_valid,
  input  wire logic                   src_first,
  input  wire logic [15:0]            src_word,
  output logic                        src_ready,
  output logic                        lut_index_valid,
  output logic      [7:0]             lut_index,
  // Alpha blending
  input  wire logic                   blend_valid,
  input  wire logic [31:0]            blend_src_pixel,
  input  wire logic [15:0]            blend_dst_pixel,
  input  wire logic [7:0]             blend_map_alpha,
  output logic                        blend_out_valid,
  output logic      [15:0]            blend_out_pixel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] key;
    logic [31:0] fill;
    logic [2:0]  exp_start;
    logic [1:0]  exp_width;
    logic [1:0]  blend_fmt;
    logic [7:0]  const_alpha;
    logic [15:0] mode;
    logic        src_lsb;
    logic [31:0] rdata;
    logic        err;
    logic        match;
    logic        match_vld;
    logic [15:0] exp_word;
    logic [4:0]  exp_left;
    logic        idx_vld;
    logic [7:0]  idx;
    logic        bl_vld;
    logic [15:0] bl_pix;
  } bcap_state_t;

  bcap_state_t s_q;
  bcap_state_t s_d;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Active color bits for a depth code; reserved code keeps all bits
  function automatic logic [31:0] depth_mask(input logic [31:0] c, input logic [1:0] d);
    logic [31:0] r;
    r = c;
    if (d == BCAP_DEPTH_16) begin
      r = {16'h0000, c[15:0]};
    end else if (d == BCAP_DEPTH_8) begin
      r = {24'h000000, c[7:0]};
    end
    return r;
  endfunction

  // Bits per index for the width field
  function automatic logic [3:0] field_bits(input logic [1:0] f);
    logic [3:0] n;
    n = 4'h1;
    case (f)
      BCAP_EXP_2BIT: n = 4'h2;
      BCAP_EXP_4BIT: n = 4'h4;
      BCAP_EXP_8BIT: n = 4'h8;
      default:       n = 4'h1;
    endcase
    return n;
  endfunction

  // Reorder the source word into the order the index walk expects
  function automatic logic [15:0] prep_word(input logic [15:0] w, input logic [1:0] f);
    logic [15:0] r;
    logic [3:0]  n;
    logic [3:0]  base;
    logic [3:0]  off;
    r = 16'h0000;
    n = field_bits(f);
    base = 4'h0;
    off = 4'h0;
    if (f == BCAP_EXP_1BIT) begin
      r = {w[7:0], w[15:8]};
    end else begin
      for (int i = 0; i < 16; i++) begin
        base = 4'(i) & ~(n - 4'h1);
        off = 4'(i) - base;
        r[base + (n - 4'h1 - off)] = w[i];
      end
    end
    return r;
  endfunction

  // Leading field of the word as a lookup index
  function automatic logic [7:0] top_field(input logic [15:0] w, input logic [1:0] f);
    logic [7:0] r;
    r = {7'h00, w[15]};
    case (f)
      BCAP_EXP_2BIT: r = {6'h00, w[15:14]};
      BCAP_EXP_4BIT: r = {4'h0, w[15:12]};
      BCAP_EXP_8BIT: r = w[15:8];
      default:       r = {7'h00, w[15]};
    endcase
    return r;
  endfunction

  // Alpha for a 2-bit selection
  function automatic logic [7:0] pick_alpha(input logic [1:0] sel, input logic [7:0] map_a,
                                            input logic [7:0] k);
    logic [7:0] a;
    a = map_a;
    case (sel)
      BCAP_ASEL_NMAP: a = 8'hff - map_a;
      BCAP_ASEL_K:    a = k;
      BCAP_ASEL_NK:   a = 8'hff - k;
      default:        a = map_a;
    endcase
    return a;
  endfunction

  // One channel: alpha weighted sum, scaled back to 8 bits and saturated
  function automatic logic [7:0] mix(input logic [7:0] sa, input logic [7:0] sc,
                                     input logic [7:0] da, input logic [7:0] dc);
    logic [16:0] sum;
    sum = 17'(sa * sc) + 17'(da * dc);
    return sum[16] ? 8'hff : sum[15:8];
  endfunction

  // Widen a channel of n bits to 8 by bit replication
  function automatic logic [7:0] widen(input logic [7:0] v, input logic [3:0] n);
    logic [7:0] r;
    r = v;
    if (n == 4'h4) begin
      r = {v[3:0], v[3:0]};
    end else if (n == 4'h5) begin
      r = {v[4:0], v[4:2]};
    end else if (n == 4'h6) begin
      r = {v[5:0], v[5:4]};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic [1:0]  depth;
  logic [2:0]  opcode;
  logic        exp_en;
  logic        alpha_en;
  logic [3:0]  eff_start;
  logic [3:0]  skip;
  logic [3:0]  nbits;
  logic [4:0]  per_word;
  logic [23:0] src_rgb;
  logic [23:0] dst_rgb;
  logic [7:0]  sa;
  logic [7:0]  da;

  assign depth    = s_q.mode[BCAP_MODE_DEPTH_LSB +: 2];
  assign opcode   = s_q.mode[BCAP_MODE_OP_LSB +: 3];
  assign exp_en   = s_q.mode[BCAP_MODE_EXP_EN];
  assign alpha_en = s_q.mode[BCAP_MODE_ALPHA_EN];
  assign nbits    = field_bits(s_q.exp_width);
  assign per_word = 5'(16 / nbits);

  // Source address bit 0 plus programmed start; zero start assumed for wide formats
  assign eff_start = {3'h0, s_q.src_lsb} + {1'b0, s_q.exp_start};
  assign skip = (s_q.exp_width == BCAP_EXP_1BIT && exp_en && src_first) ? eff_start
                                                                          : 4'h0;

  // Source pixel in blend format, widened to 8:8:8
  always_comb begin
    case (s_q.blend_fmt)
      BCAP_FMT_1555: src_rgb = {widen({3'h0, blend_src_pixel[14:10]}, 4'h5),
                                widen({3'h0, blend_src_pixel[9:5]}, 4'h5),
                                widen({3'h0, blend_src_pixel[4:0]}, 4'h5)};
      BCAP_FMT_4444: src_rgb = {widen({4'h0, blend_src_pixel[11:8]}, 4'h4),
                                widen({4'h0, blend_src_pixel[7:4]}, 4'h4),
                                widen({4'h0, blend_src_pixel[3:0]}, 4'h4)};
      default:       src_rgb = blend_src_pixel[23:0];
    endcase
  end

  // Destination is always 5:6:5
  assign dst_rgb = {widen({3'h0, blend_dst_pixel[15:11]}, 4'h5),
                    widen({2'h0, blend_dst_pixel[10:5]}, 4'h6),
                    widen({3'h0, blend_dst_pixel[4:0]}, 4'h5)};
  assign sa = pick_alpha(s_q.mode[BCAP_MODE_SRC_A_LSB +: 2], blend_map_alpha, s_q.const_alpha);
  assign da = pick_alpha(s_q.mode[BCAP_MODE_DST_A_LSB +: 2], blend_map_alpha, s_q.const_alpha);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        setup;
    logic        wr;
    logic [15:0] idx;
    logic [15:0] w;
    logic [15:0] pw;
    logic [7:0]  rr;
    logic [7:0]  gg;
    logic [7:0]  bb;
    s_d = s_q;
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    idx = paddr >> 2;
    w = pwdata[15:0];
    pw = 16'h0000;
    rr = 8'h00;
    gg = 8'h00;
    bb = 8'h00;

    // Read data and error captured in setup so the access phase answers from flops
    if (setup) begin
      s_d.err = 1'b0;
      s_d.rdata = 32'h0;
      if (paddr[1:0] != 2'h0) begin
        s_d.err = 1'b1;
      end else if (idx == BCAP_IDX_KEY_LO) begin
        s_d.rdata = {16'h0000, s_q.key[15:0]};
      end else if (idx == BCAP_IDX_KEY_HI) begin
        s_d.rdata = {16'h0000, s_q.key[31:16]};
      end else if (idx == BCAP_IDX_FILL_LO) begin
        s_d.rdata = {16'h0000, s_q.fill[15:0]};
      end else if (idx == BCAP_IDX_FILL_HI) begin
        s_d.rdata = {16'h0000, s_q.fill[31:16]};
      end else if (idx == BCAP_IDX_EXP_START) begin
        s_d.rdata = {29'h0, s_q.exp_start};
      end else if (idx == BCAP_IDX_EXP_WIDTH) begin
        s_d.rdata = {30'h0, s_q.exp_width};
      end else if (idx == BCAP_IDX_BLEND_FMT) begin
        s_d.rdata = {30'h0, s_q.blend_fmt};
      end else if (idx == BCAP_IDX_CONST_A) begin
        s_d.rdata = {24'h0, s_q.const_alpha};
      end else if (idx == BCAP_IDX_MODE) begin
        s_d.rdata = {16'h0000, s_q.mode};
      end else if (idx == BCAP_IDX_SRC_LSB) begin
        s_d.rdata = {31'h0, s_q.src_lsb};
      end else begin
        s_d.err = 1'b1;
      end
    end

    // Writes land at the access edge; unmapped writes are dropped
    if (wr && !s_q.err) begin
      if (idx == BCAP_IDX_KEY_LO) begin
        s_d.key[15:0] = w;
      end else if (idx == BCAP_IDX_KEY_HI) begin
        s_d.key[31:16] = w;
      end else if (idx == BCAP_IDX_FILL_LO) begin
        s_d.fill[15:0] = w;
      end else if (idx == BCAP_IDX_FILL_HI) begin
        s_d.fill[31:16] = w;
      end else if (idx == BCAP_IDX_EXP_START) begin
        s_d.exp_start = w[2:0];
      end else if (idx == BCAP_IDX_EXP_WIDTH) begin
        s_d.exp_width = w[1:0];
      end else if (idx == BCAP_IDX_BLEND_FMT) begin
        s_d.blend_fmt = w[1:0];
      end else if (idx == BCAP_IDX_CONST_A) begin
        s_d.const_alpha = w[7:0];
      end else if (idx == BCAP_IDX_MODE) begin
        s_d.mode = w & BCAP_MODE_MASK;
      end else if (idx == BCAP_IDX_SRC_LSB) begin
        s_d.src_lsb = w[0];
      end
    end

    // Key compare on depth-masked values
    s_d.match_vld = pixel_valid;
    s_d.match = pixel_valid &&
                (depth_mask(pixel_data, depth) == depth_mask(s_q.key, depth));

    // Index walk: emit leading field, then shift it out
    s_d.idx_vld = 1'b0;
    if (s_q.exp_left != 5'h0) begin
      s_d.idx_vld = 1'b1;
      s_d.idx = top_field(s_q.exp_word, s_q.exp_width);
      s_d.exp_word = s_q.exp_word << nbits;
      s_d.exp_left = s_q.exp_left - 5'h1;
    end else if (src_valid) begin
      s_d.exp_word = prep_word(src_word, s_q.exp_width) << skip;
      s_d.exp_left = per_word - {1'b0, skip};
    end

    // Blend, then pack to 5:6:5
    s_d.bl_vld = blend_valid && alpha_en;
    if (blend_valid && alpha_en) begin
      rr = mix(sa, src_rgb[23:16], da, dst_rgb[23:16]);
      gg = mix(sa, src_rgb[15:8], da, dst_rgb[15:8]);
      bb = mix(sa, src_rgb[7:0], da, dst_rgb[7:0]);
      pw = {rr[7:3], gg[7:2], bb[7:3]};
      s_d.bl_pix = pw;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{key: {BCAP_RST_KEY, BCAP_RST_KEY}, fill: {BCAP_RST_FILL, BCAP_RST_FILL},
               exp_start: BCAP_RST_EXP_START, exp_width: BCAP_RST_EXP_WIDTH,
               blend_fmt: BCAP_RST_BLEND_FMT, const_alpha: BCAP_RST_CONST_A,
               mode: BCAP_RST_MODE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait slave: data was captured in the setup cycle
  assign pready          = 1'b1;
  assign prdata          = s_q.rdata;
  assign pslverr         = psel && penable && s_q.err;
  assign key_match       = s_q.match;
  assign key_match_valid = s_q.match_vld;
  assign fill_active     = (opcode == BCAP_OP_FILL);
  assign fill_pixel      = depth_mask(s_q.fill, depth);
  // Blending overrides the depth select as the source format
  assign source_format   = alpha_en ? s_q.blend_fmt : depth;
  assign source_is_blend = alpha_en;
  // A new word is taken only once the previous one is fully walked
  assign src_ready       = (s_q.exp_left == 5'h0);
  assign lut_index_valid = s_q.idx_vld;
  assign lut_index       = s_q.idx;
  assign blend_out_valid = s_q.bl_vld;
  assign blend_out_pixel = s_q.bl_pix;

endmodule

// file: core/bcap_pkg.sv
// Constants, codes and register layout of the blit color and alpha parameter bank
package bcap_pkg;

  // ----------------------------------------------------------------
  // Register indices (printed offsets) and address width
  // ----------------------------------------------------------------
  localparam logic [15:0] BCAP_IDX_KEY_LO    = 16'h1850;
  localparam logic [15:0] BCAP_IDX_KEY_HI    = 16'h1852;
  localparam logic [15:0] BCAP_IDX_FILL_LO   = 16'h1854;
  localparam logic [15:0] BCAP_IDX_FILL_HI   = 16'h1856;
  localparam logic [15:0] BCAP_IDX_EXP_START = 16'h1860;
  localparam logic [15:0] BCAP_IDX_EXP_WIDTH = 16'h1862;
  localparam logic [15:0] BCAP_IDX_BLEND_FMT = 16'h1870;
  localparam logic [15:0] BCAP_IDX_CONST_A   = 16'h1872;
  localparam logic [15:0] BCAP_IDX_MODE      = 16'h1878;
  localparam logic [15:0] BCAP_IDX_SRC_LSB   = 16'h187a;
  localparam int          BCAP_ADDR_W        = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] BCAP_RST_KEY       = 16'h0000;
  localparam logic [15:0] BCAP_RST_FILL      = 16'h0000;
  localparam logic [2:0]  BCAP_RST_EXP_START = 3'h0;
  localparam logic [1:0]  BCAP_RST_EXP_WIDTH = 2'h0;
  localparam logic [1:0]  BCAP_RST_BLEND_FMT = 2'h0;
  localparam logic [7:0]  BCAP_RST_CONST_A   = 8'h00;
  localparam logic [15:0] BCAP_RST_MODE      = 16'h0000;

  // ----------------------------------------------------------------
  // Mode register field positions
  // ----------------------------------------------------------------
  localparam int BCAP_MODE_DEPTH_LSB = 0;   // Color depth select, 2 bits
  localparam int BCAP_MODE_OP_LSB    = 2;   // Operation code, 3 bits
  localparam int BCAP_MODE_EXP_EN    = 5;   // Color expansion enable
  localparam int BCAP_MODE_ALPHA_EN  = 15;  // Alpha blending enable
  localparam int BCAP_MODE_SRC_A_LSB = 8;   // Source alpha select, 2 bits
  localparam int BCAP_MODE_DST_A_LSB = 10;  // Destination alpha select, 2 bits
  localparam logic [15:0] BCAP_MODE_MASK = 16'h8f3f;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] BCAP_DEPTH_8   = 2'h0;
  localparam logic [1:0] BCAP_DEPTH_16  = 2'h1;
  localparam logic [1:0] BCAP_DEPTH_32  = 2'h2;
  localparam logic [2:0] BCAP_OP_FILL   = 3'h3;
  localparam logic [1:0] BCAP_EXP_1BIT  = 2'h0;
  localparam logic [1:0] BCAP_EXP_2BIT  = 2'h1;
  localparam logic [1:0] BCAP_EXP_4BIT  = 2'h2;
  localparam logic [1:0] BCAP_EXP_8BIT  = 2'h3;
  localparam logic [1:0] BCAP_FMT_1555  = 2'h0;
  localparam logic [1:0] BCAP_FMT_4444  = 2'h1;
  localparam logic [1:0] BCAP_FMT_8888  = 2'h2;
  localparam logic [1:0] BCAP_ASEL_MAP  = 2'h0;
  localparam logic [1:0] BCAP_ASEL_NMAP = 2'h1;
  localparam logic [1:0] BCAP_ASEL_K    = 2'h2;
  localparam logic [1:0] BCAP_ASEL_NK   = 2'h3;

endpackage

// file: tb/bcap_regs_sva.sv
// Port checker for the blit color and alpha parameter bank
`timescale 1ns/1ns
module bcap_regs_sva
  import bcap_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pixel_valid,
  input wire logic        key_match,
  input wire logic        key_match_valid,
  input wire logic [31:0] fill_pixel,
  input wire logic [1:0]  source_format,
  input wire logic        source_is_blend,
  input wire logic        src_valid,
  input wire logic        src_ready,
  input wire logic        lut_index_valid,
  input wire logic        blend_valid,
  input wire logic        blend_out_valid
);
  // ----------------------------------------------------------------
  // Relations between requests and answers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_key_latency: assert property (pixel_valid |=> key_match_valid)
    else $error("key result missing one cycle after pixel");
  a_key_qualified: assert property (key_match |-> key_match_valid)
    else $error("key match without valid");
  // Depth is only visible through source_format while blending is off
  a_fill_depth16: assert property (!source_is_blend && source_format == BCAP_DEPTH_16 |->
    fill_pixel[31:16] == 16'h0000)
    else $error("fill color upper half leaks at 16 bpp");
  a_fill_depth8: assert property (!source_is_blend && source_format == BCAP_DEPTH_8 |->
    fill_pixel[31:8] == 24'h000000)
    else $error("fill color upper bits leak at 8 bpp");
  // The word is loaded first; its leading index is registered one edge later
  a_exp_first_idx: assert property (src_valid && src_ready |=>
    !src_ready ##1 lut_index_valid)
    else $error("no index or still ready after word taken");
  a_exp_ready_last: assert property ($rose(src_ready) |-> lut_index_valid)
    else $error("ready returned without last index");
  a_blend_latency: assert property (blend_valid && source_is_blend |=> blend_out_valid)
    else $error("blend result missing");
  a_blend_off: assert property (blend_valid && !source_is_blend |=> !blend_out_valid)
    else $error("blend result while blending disabled");
endmodule

bind bcap_regs bcap_regs_sva u_sva (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .pixel_valid(pixel_valid),
  .key_match(key_match), .key_match_valid(key_match_valid), .fill_pixel(fill_pixel),
  .source_format(source_format), .source_is_blend(source_is_blend),
  .src_valid(src_valid), .src_ready(src_ready), .lut_index_valid(lut_index_valid),
  .blend_valid(blend_valid), .blend_out_valid(blend_out_valid));

// file: tb/bcap_regs_tb_top.sv
// Self-checking bench for the blit color and alpha parameter bank
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp); end end
module bcap_regs_tb_top
  import bcap_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, responses and tables
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0, reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000, src_word = 16'h0000;
  logic [31:0] pwdata = 32'h0, pixel_data = 32'h0, prdata, fill_pixel, rd_s;
  logic        pixel_valid = 1'b0, src_valid = 1'b0, src_first = 1'b0, blend_valid = 1'b0;
  logic [31:0] blend_src_pixel = 32'h00ffffff;  // White source, alpha taken from map or constant
  logic [15:0] blend_dst_pixel = 16'hf800, blend_out_pixel;  // Red, so the destination term counts
  logic [7:0]  blend_map_alpha = 8'h00, lut_index;
  logic        pready, pslverr, key_match, key_match_valid, fill_active, er_s;
  logic        source_is_blend, src_ready, lut_index_valid, blend_out_valid;
  logic [1:0]  source_format;
  int          failures = 0, checks_done = 0;
  localparam logic [15:0] IDX [10] = '{BCAP_IDX_KEY_LO, BCAP_IDX_KEY_HI, BCAP_IDX_FILL_LO,
    BCAP_IDX_FILL_HI, BCAP_IDX_EXP_START, BCAP_IDX_EXP_WIDTH, BCAP_IDX_BLEND_FMT,
    BCAP_IDX_CONST_A, BCAP_IDX_MODE, BCAP_IDX_SRC_LSB};
  localparam logic [15:0] MSK [10] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0007,
    16'h0003, 16'h0003, 16'h00ff, BCAP_MODE_MASK, 16'h0001};
  // Expansion of 1234h, indexes packed most significant byte first
  localparam logic [127:0] S1 = 128'h00000101_00010000_00000001_00000100;
  localparam logic [127:0] SK = 128'h00010000_00000001_00000100_00000000;
  localparam logic [127:0] ES [6] = '{S1, 128'h00020001_00030200_00000000_00000000,
    128'h08040c02_00000000_00000000_00000000, 128'h482c0000_00000000_00000000_00000000,
    SK, S1};
  localparam logic [1:0]  EW [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  localparam logic [15:0] EM [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0020, 16'h0};
  localparam int          EN [6] = '{16, 8, 4, 2, 12, 16};
  localparam logic [15:0] BM [4] = '{16'h8e00, 16'h8b00, 16'h8400, 16'h8100};
  localparam logic [7:0]  BA [4] = '{8'h00, 8'h00, 8'hff, 8'h00};
  localparam logic [15:0] BE [4] = '{16'hfbef, 16'hfbef, 16'hffff, 16'hffff};

  bcap_regs dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pixel_valid(pixel_valid), .pixel_data(pixel_data),
    .key_match(key_match), .key_match_valid(key_match_valid), .fill_active(fill_active),
    .fill_pixel(fill_pixel), .source_format(source_format), .source_is_blend(source_is_blend),
    .src_valid(src_valid), .src_first(src_first), .src_word(src_word), .src_ready(src_ready),
    .lut_index_valid(lut_index_valid), .lut_index(lut_index), .blend_valid(blend_valid),
    .blend_src_pixel(blend_src_pixel), .blend_dst_pixel(blend_dst_pixel),
    .blend_map_alpha(blend_map_alpha), .blend_out_valid(blend_out_valid),
    .blend_out_pixel(blend_out_pixel));

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] ba(input logic [15:0] idx);
    return 16'(idx << 2);  // Printed offsets are word indexes
  endfunction

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd_s = prdata;
    er_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    apb(1'b1, ba(idx), {16'h0000, d});
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rd_s, e, "read data")
    `CHK(er_s, ee, "slave error")
  endtask

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask

  task automatic pix(input logic [31:0] p, input logic e);
    @(posedge clk_sys);
    pixel_valid <= 1'b1;
    pixel_data <= p;
    @(posedge clk_sys);
    pixel_valid <= 1'b0;
    #1;
    `CHK(key_match_valid, 1'b1, "key valid")
    `CHK(key_match, e, "key match")
  endtask

  task automatic blend(input logic [15:0] m, input logic [7:0] a, input logic v,
                       input logic [15:0] e);
    wr(BCAP_IDX_MODE, m);
    @(posedge clk_sys);
    blend_valid <= 1'b1;
    blend_map_alpha <= a;
    @(posedge clk_sys);
    blend_valid <= 1'b0;
    #1;
    `CHK(blend_out_valid, v, "blend valid")
    if (v) `CHK(blend_out_pixel, e, "blend pixel")
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: the sequence needs roughly 400 cycles
  initial begin
    #(50 * 20000);
    failures++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] m;
    do_reset();
    foreach (IDX[i]) rchk(ba(IDX[i]), 32'h0, 1'b0);
    foreach (IDX[i]) wr(IDX[i], 16'hffff);
    foreach (IDX[i]) rchk(ba(IDX[i]), {16'h0000, MSK[i]}, 1'b0);
    apb(1'b1, ba(BCAP_IDX_KEY_LO) | 16'h0002, 32'h5a5a);  // Misaligned write is dropped
    rchk(ba(BCAP_IDX_KEY_LO) | 16'h0002, 32'h0, 1'b1);
    rchk(ba(16'h1851), 32'h0, 1'b1);
    rchk(ba(BCAP_IDX_KEY_LO), 32'h0000ffff, 1'b0);
    do_reset();
    foreach (IDX[i]) rchk(ba(IDX[i]), 32'h0, 1'b0);
    $display("test registers done");
    wr(BCAP_IDX_KEY_LO, 16'h5678);
    wr(BCAP_IDX_KEY_HI, 16'h1234);
    wr(BCAP_IDX_FILL_LO, 16'hcdef);
    wr(BCAP_IDX_FILL_HI, 16'h89ab);
    for (int d = 0; d < 4; d++) begin
      wr(BCAP_IDX_MODE, 16'(d) | 16'h000c);
      m = (d == 0) ? 32'h000000ff : (d == 1) ? 32'h0000ffff : 32'hffffffff;
      #1;
      `CHK(fill_active, 1'b1, "fill active")
      `CHK(fill_pixel, 32'h89abcdef & m, "fill pixel")
      pix(32'haaaa5678, d < 2);
      pix(32'haaaaaa78, d == 0);
      pix(32'h12345678, 1'b1);
    end
    wr(BCAP_IDX_MODE, 16'h0008);
    #1;
    `CHK(fill_active, 1'b0, "fill inactive")
    $display("test key and fill done");
    for (int i = 0; i < 6; i++) begin
      wr(BCAP_IDX_EXP_WIDTH, {14'h0, EW[i]});
      wr(BCAP_IDX_EXP_START, (i > 3) ? 16'h0003 : 16'h0000);
      wr(BCAP_IDX_SRC_LSB, (i > 3) ? 16'h0001 : 16'h0000);
      wr(BCAP_IDX_MODE, EM[i]);
      @(posedge clk_sys);
      src_valid <= 1'b1;
      src_first <= 1'b1;
      src_word <= 16'h1234;
      @(posedge clk_sys);
      src_valid <= 1'b0;
      @(posedge clk_sys);  // The word is loaded first, the leading index one edge later
      for (int k = 0; k < EN[i]; k++) begin
        #1;
        `CHK(lut_index_valid, 1'b1, "index valid")
        `CHK(lut_index, ES[i][127-8*k -: 8], "lut index")
        @(posedge clk_sys);
      end
      #1;
      `CHK(lut_index_valid, 1'b0, "index count")
      `CHK(src_ready, 1'b1, "source ready")
    end
    $display("test expansion done");
    for (int f = 0; f < 3; f++) begin
      wr(BCAP_IDX_BLEND_FMT, 16'(f));
      wr(BCAP_IDX_MODE, 16'h8001);
      #1;
      `CHK(source_format, 2'(f), "blend format")
      `CHK(source_is_blend, 1'b1, "blend enable")
    end
    wr(BCAP_IDX_MODE, 16'h0001);
    #1;
    `CHK(source_format, BCAP_DEPTH_16, "depth format")
    wr(BCAP_IDX_CONST_A, 16'h0080);
    foreach (BM[i]) blend(BM[i], BA[i], 1'b1, BE[i]);
    blend(16'h0e00, 8'h00, 1'b0, 16'h0000);
    $display("test blend done");
    report_and_stop();
  end
endmodule
